// [rtl/mtc_regs.vh]
`ifndef MTC_REGS_VH
`define MTC_REGS_VH

// Bus widths
`define MTC_AW          4
`define MTC_DW          16
`define MTC_NT          3
`define MTC_NI          2

// Address split: bank in the upper bits, field in the lower bits
`define MTC_BANK_HI     3
`define MTC_BANK_LO     2
`define MTC_FLD_HI      1
`define MTC_FLD_LO      0
`define MTC_FLD_COUNT   2'h0
`define MTC_FLD_MAX     2'h1
`define MTC_FLD_CTRL    2'h2
`define MTC_BANK_IRQ    2'h3
`define MTC_ADDR_ISTAT  4'hc
`define MTC_ADDR_IMASK  4'hd

// Control register layout
`define MTC_CTL_W       6
`define MTC_CTL_EN      0
`define MTC_CTL_INH     1
`define MTC_CTL_AUTO    2
`define MTC_CTL_EXT     3
`define MTC_CTL_PRE     4
`define MTC_CTL_MCF     5
`define MTC_CTL_RST     6'h00
`define MTC_CTL_T2MASK  6'h27

// Count values
`define MTC_MAX_RST     16'h0000
`define MTC_CNT_ZERO    16'h0000
`define MTC_CNT_STEP    16'h0001
`define MTC_RD_IDLE     16'h0000
`define MTC_IRQ_RST     3'h0

// Service slots, one-hot
`define MTC_SLOT_W      4
`define MTC_SLOT_T0     4'h1
`define MTC_SLOT_T1     4'h2
`define MTC_SLOT_T2     4'h4
`define MTC_SLOT_GAP    4'h8

`endif

// [rtl/mtc_sync.v]
`timescale 1ns/1ps
`include "mtc_regs.vh"

module mtc_sync (
	input  wire clk_sys,
	input  wire rst,
	input  wire pin_in,
	output reg  rise
);

	reg stage1_reg;
	reg stage2_reg;
	reg prev_reg;

	// Only stage2 reads stage1; edge detection runs after it
	always @(posedge clk_sys) begin
		if (rst) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
			prev_reg   <= 1'b0;
			rise       <= 1'b0;
		end else begin
			stage1_reg <= pin_in;
			stage2_reg <= stage1_reg;
			prev_reg   <= stage2_reg;
			rise       <= stage2_reg & ~prev_reg;
		end
	end

endmodule

// [rtl/mtc_timer.v]
`timescale 1ns/1ps
`include "mtc_regs.vh"

module mtc_timer (
	input  wire                  clk_sys,
	input  wire                  rst,
	input  wire [`MTC_AW-1:0]    addr,
	input  wire [`MTC_DW-1:0]    wdata,
	input  wire                  wr,
	input  wire                  rd,
	output reg  [`MTC_DW-1:0]    rdata,
	input  wire [`MTC_NI-1:0]    timer_event_input,
	output reg  [`MTC_NT-1:0]    max_count_pulse,
	output reg  [`MTC_NT-1:0]    timer_running,
	output wire                  irq
);

	localparam SLOT_T0  = `MTC_SLOT_T0;
	localparam SLOT_T1  = `MTC_SLOT_T1;
	localparam SLOT_T2  = `MTC_SLOT_T2;
	localparam SLOT_GAP = `MTC_SLOT_GAP;

	////////////////////////////////////////////////////////////////////
	// Address decoding

	function [1:0] bank_of;
		input [`MTC_AW-1:0] a;
		begin
			bank_of = a[`MTC_BANK_HI:`MTC_BANK_LO];
		end
	endfunction

	function [1:0] field_of;
		input [`MTC_AW-1:0] a;
		begin
			field_of = a[`MTC_FLD_HI:`MTC_FLD_LO];
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// State

	reg [`MTC_DW-1:0]    count_reg [0:`MTC_NT-1];
	reg [`MTC_DW-1:0]    max_reg   [0:`MTC_NT-1];
	reg [`MTC_CTL_W-1:0] ctrl_reg  [0:`MTC_NT-1];
	reg [`MTC_DW-1:0]    count_next [0:`MTC_NT-1];
	reg [`MTC_DW-1:0]    max_next   [0:`MTC_NT-1];
	reg [`MTC_CTL_W-1:0] ctrl_next  [0:`MTC_NT-1];

	reg [`MTC_SLOT_W-1:0] slot_reg;
	reg [`MTC_SLOT_W-1:0] slot_next;

	reg                  wp_reg;
	reg [`MTC_AW-1:0]    wa_reg;
	reg [`MTC_DW-1:0]    wd_reg;

	reg [`MTC_NI-1:0]    edge_pend_reg;
	reg [`MTC_NI-1:0]    t2_pend_reg;
	reg [`MTC_NT-1:0]    istat_reg;
	reg [`MTC_NT-1:0]    imask_reg;

	wire [`MTC_NI-1:0]   pin_rise;
	wire [`MTC_NT-1:0]   svc;
	reg  [`MTC_NT-1:0]   event_ok;
	reg  [`MTC_NT-1:0]   hit;
	reg  [`MTC_NT-1:0]   step;
	reg  [`MTC_DW-1:0]   inc_val;
	reg  [`MTC_DW-1:0]   rd_mux;

	integer i;
	integer ev_i;
	integer ck_i;
	integer st_i;
	integer pd_i;
	integer ir_i;

	////////////////////////////////////////////////////////////////////
	// Timer input synchronisers, one per external input

	genvar g;
	generate
		for (g = 0; g < `MTC_NI; g = g + 1) begin : g_in
			mtc_sync u_sync (
				.clk_sys (clk_sys),
				.rst     (rst),
				.pin_in  (timer_event_input[g]),
				.rise    (pin_rise[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Service rotation: one bank per slot, one idle slot

	// Free-running; bus activity never touches the rotation
	always @* begin
		case (slot_reg)
			SLOT_T0: begin
				slot_next = SLOT_T1;
			end
			SLOT_T1: begin
				slot_next = SLOT_T2;
			end
			SLOT_T2: begin
				slot_next = SLOT_GAP;
			end
			SLOT_GAP: begin
				slot_next = SLOT_T0;
			end
			default: begin
				slot_next = SLOT_T0;
			end
		endcase
	end

	assign svc = slot_reg[`MTC_NT-1:0];

	////////////////////////////////////////////////////////////////////
	// Counter element

	always @* begin
		for (ev_i = 0; ev_i < `MTC_NT; ev_i = ev_i + 1) begin
			if (ev_i == `MTC_NT - 1)
				event_ok[ev_i] = 1'b1;
			else if (ctrl_reg[ev_i][`MTC_CTL_EXT])
				event_ok[ev_i] = edge_pend_reg[ev_i];
			else if (ctrl_reg[ev_i][`MTC_CTL_PRE])
				event_ok[ev_i] = t2_pend_reg[ev_i];
			else
				event_ok[ev_i] = 1'b1;
			step[ev_i] = svc[ev_i] & ctrl_reg[ev_i][`MTC_CTL_EN] &
				event_ok[ev_i];
			inc_val = count_reg[ev_i] + `MTC_CNT_STEP;
			// Zero maximum matches after the 16-bit wrap
			hit[ev_i] = step[ev_i] &
				(inc_val == max_reg[ev_i]);
		end
	end

	// Hardware update first, then a landing bus write on top
	always @* begin
		for (i = 0; i < `MTC_NT; i = i + 1) begin
			count_next[i] = count_reg[i];
			max_next[i]   = max_reg[i];
			ctrl_next[i]  = ctrl_reg[i];
			if (step[i]) begin
				count_next[i] = hit[i] ? `MTC_CNT_ZERO :
					count_reg[i] + `MTC_CNT_STEP;
			end
			if (hit[i] && !ctrl_reg[i][`MTC_CTL_AUTO]) begin
				ctrl_next[i][`MTC_CTL_EN] = 1'b0;
			end
			if (wp_reg && bank_of(wa_reg) == i) begin
				case (field_of(wa_reg))
					`MTC_FLD_COUNT: begin
						count_next[i] = wd_reg;
					end
					`MTC_FLD_MAX: begin
						max_next[i] = wd_reg;
					end
					`MTC_FLD_CTRL: begin
						if (wd_reg[`MTC_CTL_INH])
							ctrl_next[i][`MTC_CTL_EN] =
								wd_reg[`MTC_CTL_EN];
						ctrl_next[i][`MTC_CTL_AUTO] =
							wd_reg[`MTC_CTL_AUTO];
						ctrl_next[i][`MTC_CTL_EXT] =
							wd_reg[`MTC_CTL_EXT];
						ctrl_next[i][`MTC_CTL_PRE] =
							wd_reg[`MTC_CTL_PRE];
						ctrl_next[i][`MTC_CTL_MCF] =
							ctrl_reg[i][`MTC_CTL_MCF] &
							wd_reg[`MTC_CTL_MCF];
					end
					default: begin
						ctrl_next[i] = ctrl_next[i];
					end
				endcase
			end
			// Set beats a simultaneous software clear
			if (hit[i])
				ctrl_next[i][`MTC_CTL_MCF] = 1'b1;
			ctrl_next[i][`MTC_CTL_INH] = 1'b0;
			// Last timer has only the internal clock source
			if (i == `MTC_NT - 1)
				ctrl_next[i] = ctrl_next[i] & `MTC_CTL_T2MASK;
		end
	end

	// Counts keep no reset value; software must load them
	always @(posedge clk_sys) begin
		for (ck_i = 0; ck_i < `MTC_NT; ck_i = ck_i + 1)
			count_reg[ck_i] <= count_next[ck_i];
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			for (st_i = 0; st_i < `MTC_NT; st_i = st_i + 1) begin
				max_reg[st_i]  <= `MTC_MAX_RST;
				ctrl_reg[st_i] <= `MTC_CTL_RST;
			end
			slot_reg <= SLOT_T0;
		end else begin
			for (st_i = 0; st_i < `MTC_NT; st_i = st_i + 1) begin
				max_reg[st_i]  <= max_next[st_i];
				ctrl_reg[st_i] <= ctrl_next[st_i];
			end
			slot_reg <= slot_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Latched events for timers with external sources

	// Edges are held until the bank's slot comes round
	always @(posedge clk_sys) begin
		if (rst) begin
			edge_pend_reg <= {`MTC_NI{1'b0}};
			t2_pend_reg   <= {`MTC_NI{1'b0}};
		end else begin
			for (pd_i = 0; pd_i < `MTC_NI; pd_i = pd_i + 1) begin
				edge_pend_reg[pd_i] <= pin_rise[pd_i] |
					(edge_pend_reg[pd_i] & ~svc[pd_i]);
				t2_pend_reg[pd_i] <= hit[`MTC_NT-1] |
					(t2_pend_reg[pd_i] & ~svc[pd_i]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register port

	// Write lands one edge late: that edge is the wait state
	always @(posedge clk_sys) begin
		if (rst) begin
			wp_reg <= 1'b0;
			wa_reg <= {`MTC_AW{1'b0}};
			wd_reg <= `MTC_RD_IDLE;
		end else begin
			wp_reg <= wr;
			wa_reg <= addr;
			wd_reg <= wdata;
		end
	end

	// Whole-word snapshot, so a read never sees half a count
	always @* begin
		rd_mux = `MTC_RD_IDLE;
		if (addr == `MTC_ADDR_ISTAT) begin
			rd_mux[`MTC_NT-1:0] = istat_reg;
		end else if (addr == `MTC_ADDR_IMASK) begin
			rd_mux[`MTC_NT-1:0] = imask_reg;
		end else if (bank_of(addr) != `MTC_BANK_IRQ) begin
			case (field_of(addr))
				`MTC_FLD_COUNT: begin
					rd_mux = count_reg[bank_of(addr)];
				end
				`MTC_FLD_MAX: begin
					rd_mux = max_reg[bank_of(addr)];
				end
				`MTC_FLD_CTRL: begin
					rd_mux[`MTC_CTL_W-1:0] =
						ctrl_reg[bank_of(addr)];
				end
				default: begin
					rd_mux = `MTC_RD_IDLE;
				end
			endcase
		end
	end

	// Counter keeps running while the bus reads; nothing stalls it
	always @(posedge clk_sys) begin
		if (rst)
			rdata <= `MTC_RD_IDLE;
		else if (rd)
			rdata <= rd_mux;
		else
			rdata <= `MTC_RD_IDLE;
	end

	////////////////////////////////////////////////////////////////////
	// Interrupts and status

	// Read clears status; a same-cycle event still lands
	always @(posedge clk_sys) begin
		if (rst) begin
			istat_reg       <= `MTC_IRQ_RST;
			imask_reg       <= `MTC_IRQ_RST;
			max_count_pulse <= `MTC_IRQ_RST;
			timer_running   <= `MTC_IRQ_RST;
		end else begin
			if (rd && addr == `MTC_ADDR_ISTAT)
				istat_reg <= hit;
			else
				istat_reg <= istat_reg | hit;
			if (wp_reg && wa_reg == `MTC_ADDR_IMASK)
				imask_reg <= wd_reg[`MTC_NT-1:0];
			max_count_pulse <= hit;
			for (ir_i = 0; ir_i < `MTC_NT; ir_i = ir_i + 1)
				timer_running[ir_i] <= ctrl_next[ir_i][`MTC_CTL_EN];
		end
	end

	assign irq = |(istat_reg & imask_reg);

endmodule

// [verif/mtc_timer_asserts.sv]
`timescale 1ns/1ps
`include "mtc_regs.vh"
module mtc_chk (
	input wire logic               clk_sys,
	input wire logic               rst,
	input wire logic [`MTC_AW-1:0] addr,
	input wire logic               rd,
	input wire logic               wr,
	input wire logic [`MTC_DW-1:0] rdata,
	input wire logic [`MTC_NT-1:0] max_count_pulse,
	input wire logic [`MTC_NT-1:0] timer_running,
	input wire logic               irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	rdata_idle_a: assert property (
		!$past(rd) |-> rdata == 16'h0000) else $error("rdata not idle");
	rdata_unmap_a: assert property (
		$past(rd) && $past(addr) == 4'hf |-> rdata == 16'h0000)
		else $error("hole read not zero");
	rst_clear_a: assert property (
		$past(rst) |-> !irq && max_count_pulse == 3'h0 &&
		timer_running == 3'h0) else $error("outputs not cleared");
	pulse_gap_a: assert property (
		max_count_pulse[0] |=> !max_count_pulse[0] [*3])
		else $error("service faster than four clocks");
	pulse_en_a: assert property (
		max_count_pulse[1] |-> $past(timer_running[1]))
		else $error("disabled timer hit maximum");
	run_stop_a: assert property (
		$fell(timer_running[0]) |-> max_count_pulse[0] || $past(wr) ||
		$past(wr, 2)) else $error("enable lost without cause");
	irq_rise_a: assert property (
		$rose(irq) |-> max_count_pulse != 3'h0 || $past(wr) ||
		$past(wr, 2)) else $error("irq without maximum hit");
	irq_fall_a: assert property (
		$fell(irq) |-> $past(rd) || $past(rd, 2) || $past(wr) ||
		$past(wr, 2)) else $error("irq dropped by itself");

	cover property (max_count_pulse[0]);
	cover property (max_count_pulse[2]);
	cover property ($fell(irq));
endmodule

bind mtc_timer mtc_chk chk_u (
	.clk_sys(clk_sys), .rst(rst), .addr(addr), .rd(rd), .wr(wr),
	.rdata(rdata), .max_count_pulse(max_count_pulse),
	.timer_running(timer_running), .irq(irq)
);

// [verif/mtc_pin_src.sv]
`timescale 1ns/1ps
module mtc_pin_src (
	input  wire logic       clk_sys,
	input  wire logic [1:0] run,
	output logic      [1:0] pins
);
	logic [2:0] ph_reg = 3'h0;

	initial pins = 2'h0;
	// Half period of 8 clocks keeps rises apart beyond one service
	always @(posedge clk_sys) begin
		ph_reg <= ph_reg + 3'h1;
		if (ph_reg == 3'h7)
			pins <= run & ~pins;
	end
endmodule

// [verif/multiplexed_timer_counter_tb.sv]
`timescale 1ns/1ps
module multiplexed_timer_counter_tb;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] rdata;
	logic [1:0]  run = 2'h0;
	logic [1:0]  pins;
	logic [1:0]  pin_q = 2'h0;
	logic [2:0]  mcp;
	logic [2:0]  trun;
	logic        irq;
	int          n_fail = 0;
	int          check_count = 0;
	int          p2 = 0;
	int          rs = 0;
	int          n;
	int          i;

	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		pin_q <= pins;
		if (mcp[2] === 1'b1)
			p2 <= p2 + 1;
		if ((pins & ~pin_q) != 2'h0)
			rs <= rs + 1;
	end

	mtc_timer dut_u (
		.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .timer_event_input(pins),
		.max_count_pulse(mcp), .timer_running(trun), .irq(irq)
	);
	mtc_pin_src src_u (.clk_sys(clk_sys), .run(run), .pins(pins));

	////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input string nm, input logic [3:0] a,
		input logic [15:0] e);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 chk(nm, rdata, e);
	endtask

	task automatic wait_mc(input int t);
		#1;
		n = 0;
		while (mcp[t] !== 1'b1 && n < 300) begin
			@(posedge clk_sys);
			#1 n++;
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#20000;
		n_fail++;
		results;
	end

	////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		rd_chk("ctrl0", 4'h2, 16'h0000);
		rd_chk("max2", 4'h9, 16'h0000);
		rd_chk("hole", 4'hf, 16'h0000);
		$display("test reset done");
		// One-shot timer 0 on the internal clock pulse
		wr_reg(4'hd, 16'h0007);
		wr_reg(4'h0, 16'h0000);
		wr_reg(4'h1, 16'h0005);
		wr_reg(4'h2, 16'h0001);
		rd_chk("noinh", 4'h2, 16'h0000);
		wr_reg(4'h2, 16'h0003);
		rd_chk("inh", 4'h2, 16'h0001);
		chk("run", {13'h0000, trun}, 16'h0001);
		wait_mc(0);
		chk("run0", {13'h0000, trun}, 16'h0000);
		chk("irq", {15'h0000, irq}, 16'h0001);
		rd_chk("cnt0", 4'h0, 16'h0000);
		rd_chk("ctl0", 4'h2, 16'h0020);
		rd_chk("stat", 4'hc, 16'h0001);
		rd_chk("stat2", 4'hc, 16'h0000);
		chk("irq0", {15'h0000, irq}, 16'h0000);
		wr_reg(4'h2, 16'h0000);
		rd_chk("mcclr", 4'h2, 16'h0000);
		$display("test one-shot done");
		// Timer 1 counts timer 2 hits; timer 2 starts above its max
		wr_reg(4'h4, 16'h0000);
		wr_reg(4'h5, 16'h0000);
		wr_reg(4'h6, 16'h0013);
		wr_reg(4'h8, 16'hfffd);
		wr_reg(4'h9, 16'h0002);
		wr_reg(4'ha, 16'h0007);
		wait_mc(2);
		chk("wrap", 16'(n > 14 && n < 25), 16'h0001);
		repeat (60) @(posedge clk_sys);
		wr_reg(4'ha, 16'h0002);
		repeat (12) @(posedge clk_sys);
		rd_chk("pre", 4'h4, 16'(p2));
		$display("test prescale done");
		for (i = 0; i < 2; i++) begin
			wr_reg(4'(4 * i), 16'h0000);
			wr_reg(4'(4 * i + 1), 16'h0005);
			wr_reg(4'(4 * i + 2), 16'h000f);
			rs = 0;
			run <= 2'(1 << i);
			repeat (100) @(posedge clk_sys);
			run <= 2'h0;
			repeat (16) @(posedge clk_sys);
			rd_chk("ext", 4'(4 * i), 16'(rs % 5));
		end
		$display("test pins done");
		results;
	end
endmodule
